/* File: design/bra_pkg.sv */
// package for the ring and batch stream arbiter: register map, fields, types
// assumes a single 250 MHz clock domain and an axi4-lite register port
`default_nettype none

package bra_pkg;

	localparam int AXI_AW = 8;
	localparam int OFS_W = 19;
	localparam int ADDR_W = 32;
	localparam int LEN_W = 32;
	localparam int EVT_W = 4;
	localparam int EVT_SEL_W = 2;

	////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses)
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [AXI_AW-1:0] REG_ERR_HDR = 8'h08;
	localparam logic [AXI_AW-1:0] REG_ERR_INFO = 8'h0c;

	// control fields
	localparam int CTRL_LP_VALID = 0;
	localparam int CTRL_IRQ_VALID = 1;
	localparam int CTRL_INT_EN = 2;
	localparam int CTRL_INT_MASK = 3;
	localparam int CTRL_HWS_EN = 4;
	localparam int CTRL_HWS_MASK = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

	// status fields
	localparam int STAT_HALT = 0;
	localparam int STAT_SRC = 1;
	localparam int STAT_ARB_EN = 4;
	localparam int STAT_WAIT = 5;
	localparam int STAT_BACT = 7;
	localparam int STAT_PROT = 9;

	// error info fields
	localparam int INFO_ORIGIN = 0;
	localparam int INFO_CODE = 8;
	localparam logic [7:0] ERR_CODE_STORE_IMM = 8'h01;

	localparam int RING_LP = 0;
	localparam int RING_IRQ = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_LP_RING,
		SRC_IRQ_RING,
		SRC_LP_BATCH,
		SRC_IRQ_BATCH
	} bra_src_e;

	typedef enum logic [2:0] {
		KIND_OTHER,
		KIND_BATCH,
		KIND_ARB,
		KIND_WAIT,
		KIND_STORE_IMM
	} bra_kind_e;

	typedef enum logic [1:0] {
		ST_ARB,
		ST_RUN,
		ST_STALL,
		ST_HALT
	} bra_st_e;

endpackage

`default_nettype wire

/* File: design/bra_pick.sv */
// priority picker for the four instruction sources
// assumes inputs already reflect ring validity, emptiness and waits
`default_nettype none

module bra_pick
	import bra_pkg::*;
(
	input wire logic irq_bact,
	input wire logic lp_bact,
	input wire logic lp_pend,
	input wire logic irq_rdy,
	input wire logic irq_arb_en,
	input wire logic lp_rdy,
	output bra_pkg::bra_src_e pick
);

	always_comb
	begin
		// irq batch is never broken, even at its chain points
		if (irq_bact)
			pick = SRC_IRQ_BATCH;
		else if (lp_bact && !lp_pend)
			pick = SRC_LP_BATCH;
		else if (irq_rdy && irq_arb_en)
			pick = SRC_IRQ_RING;
		else if (lp_bact)
			pick = SRC_LP_BATCH;
		else if (lp_rdy)
			pick = SRC_LP_RING;
		else
			pick = SRC_NONE;
	end

endmodule

`default_nettype wire

/* File: design/bra_arbiter.sv */
// ring and batch stream arbiter of the instruction parser
// assumes a fetch engine that streams decoded instructions from the selected
// source, and ring head/tail offsets kept by ring pointer logic on this clock
//
// Operation
// - a batch start from a ring starts a batch fetch at its address and length
// - a batch start ending a batch chains into the new batch, no ring return
// - a batch ending otherwise resumes the ring after the original batch start
// - four sources tracked: two rings and one batch sequence per ring
// - arbitration toggle from the low-priority stream gates the interrupt ring
// - low-priority batch is not preempted; interrupt ring enters only at chain points
// - a batch started from the interrupt ring is never interrupted
// - wait from a ring marks that ring empty until its event arrives
// - wait from a batch stalls the parser without rearbitration
// - with nothing pending, arbitrate every cycle
// - arbitrate between consecutive low-priority ring instructions
// - arbitrate after a low-priority ring batch start and at low-priority batch end
// - interrupt ring wait arbitrates only when it really has to wait
// - continuing the active batch has highest priority
// - then interrupt ring if enabled, then low-priority batch, then low-priority ring
// - batch start carries an untrusted flag selecting protected mode
// - protected batches refuse the immediate store-dword instruction
// - protection from the ring batch start persists across chained batches
// - a violation captures header, origin and error code
// - a violation raises interrupt and/or status write when enabled and unmasked
// - after a violation the parser halts until reset
// - a ring arbitrates only while its valid bit is set
// - a ring with head equal to tail has nothing pending
`default_nettype none

module bra_arbiter
	import bra_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [bra_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bra_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [bra_pkg::OFS_W-1:0] lp_head,
	input wire logic [bra_pkg::OFS_W-1:0] lp_tail,
	input wire logic [bra_pkg::OFS_W-1:0] irq_head,
	input wire logic [bra_pkg::OFS_W-1:0] irq_tail,
	input wire logic [bra_pkg::EVT_W-1:0] evt_in,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [31:0] instr_header,
	input wire bra_pkg::bra_kind_e instr_kind,
	input wire logic instr_last,
	input wire logic [bra_pkg::ADDR_W-1:0] instr_batch_addr,
	input wire logic [bra_pkg::LEN_W-1:0] instr_batch_len,
	input wire logic instr_untrusted,
	input wire logic instr_arb_on,
	input wire logic [bra_pkg::EVT_SEL_W-1:0] instr_evt_sel,
	output bra_pkg::bra_src_e src_sel,
	output logic src_go,
	output logic batch_go,
	output logic [bra_pkg::ADDR_W-1:0] batch_addr,
	output logic [bra_pkg::LEN_W-1:0] batch_len,
	output logic prot_mode,
	output logic halted,
	output logic viol_irq,
	output logic viol_hws_req
);

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] status_word;
	logic [31:0] err_hdr_reg, err_hdr_next;
	logic [31:0] err_info_reg, err_info_next;

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready = !w_have_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	always_comb
	begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		aw_addr_next = aw_addr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		ctrl_next = ctrl_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb0_next = s_axi_wstrb[0];
		end
		// address and data may land in either order; commit once both are here
		if (aw_have_reg && w_have_reg)
		begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			if (aw_addr_reg == REG_CTRL)
			begin
				if (wstrb0_reg)
					ctrl_next = wdata_reg[CTRL_W-1:0];
			end
			else if (aw_addr_reg != REG_STATUS && aw_addr_reg != REG_ERR_HDR &&
				aw_addr_reg != REG_ERR_INFO)
				bresp_next = RESP_SLVERR;
		end
		else if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: rdata_next = {{(32-CTRL_W){1'b0}}, ctrl_reg};
				REG_STATUS: rdata_next = status_word;
				REG_ERR_HDR: rdata_next = err_hdr_reg;
				REG_ERR_INFO: rdata_next = err_info_reg;
				default:
				begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			ctrl_reg <= CTRL_RST;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_addr_reg <= aw_addr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			ctrl_reg <= ctrl_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arbitration core

	function automatic logic ring_ready(input logic valid, input logic waiting,
		input logic [OFS_W-1:0] head, input logic [OFS_W-1:0] tail);
		ring_ready = valid && !waiting && (head != tail);
	endfunction

	bra_st_e st_reg, st_next;
	bra_src_e src_reg, src_next;
	bra_src_e pick;
	logic [1:0] bact_reg, bact_next;
	logic [1:0] pend_reg, pend_next;
	logic [1:0] prot_reg, prot_next;
	logic [ADDR_W-1:0] baddr_reg [2];
	logic [ADDR_W-1:0] baddr_next [2];
	logic [LEN_W-1:0] blen_reg [2];
	logic [LEN_W-1:0] blen_next [2];
	logic [1:0] wait_reg, wait_next;
	logic [EVT_SEL_W-1:0] wsel_reg [2];
	logic [EVT_SEL_W-1:0] wsel_next [2];
	logic [EVT_SEL_W-1:0] stall_sel_reg, stall_sel_next;
	logic arb_en_reg, arb_en_next;
	logic src_go_reg, src_go_next;
	logic batch_go_reg, batch_go_next;
	logic [ADDR_W-1:0] oaddr_reg, oaddr_next;
	logic [LEN_W-1:0] olen_reg, olen_next;
	logic virq_reg, virq_next;
	logic vhws_reg, vhws_next;
	logic lp_rdy, irq_rdy, take, from_batch, evt_hit;
	int ring;

	assign lp_rdy = ring_ready(ctrl_reg[CTRL_LP_VALID], wait_reg[RING_LP], lp_head, lp_tail);
	assign irq_rdy = ring_ready(ctrl_reg[CTRL_IRQ_VALID], wait_reg[RING_IRQ], irq_head,
		irq_tail);
	assign instr_ready = (st_reg == ST_RUN);
	assign take = instr_valid && instr_ready;
	assign from_batch = (src_reg == SRC_LP_BATCH) || (src_reg == SRC_IRQ_BATCH);
	assign ring = (src_reg == SRC_IRQ_RING || src_reg == SRC_IRQ_BATCH) ? RING_IRQ : RING_LP;
	assign evt_hit = evt_in[instr_evt_sel];

	bra_pick u_pick (
		.irq_bact(bact_reg[RING_IRQ]),
		.lp_bact(bact_reg[RING_LP]),
		.lp_pend(pend_reg[RING_LP]),
		.irq_rdy(irq_rdy),
		.irq_arb_en(arb_en_reg),
		.lp_rdy(lp_rdy),
		.pick(pick)
	);

	always_comb
	begin
		st_next = st_reg;
		src_next = src_reg;
		bact_next = bact_reg;
		pend_next = pend_reg;
		prot_next = prot_reg;
		baddr_next = baddr_reg;
		blen_next = blen_reg;
		wait_next = wait_reg;
		wsel_next = wsel_reg;
		stall_sel_next = stall_sel_reg;
		arb_en_next = arb_en_reg;
		err_hdr_next = err_hdr_reg;
		err_info_next = err_info_reg;
		oaddr_next = oaddr_reg;
		olen_next = olen_reg;
		src_go_next = 1'b0;
		batch_go_next = 1'b0;
		virq_next = 1'b0;
		vhws_next = 1'b0;
		// awaited events hand the ring back to arbitration
		for (int r = 0; r < 2; r++)
			if (wait_reg[r] && evt_in[wsel_reg[r]])
				wait_next[r] = 1'b0;
		unique case (st_reg)
			ST_ARB:
			begin
				// stays here every cycle while nothing is pending
				if (pick != SRC_NONE)
				begin
					src_next = pick;
					src_go_next = 1'b1;
					st_next = ST_RUN;
					if (pick == SRC_LP_BATCH && pend_reg[RING_LP])
					begin
						pend_next[RING_LP] = 1'b0;
						batch_go_next = 1'b1;
						oaddr_next = baddr_reg[RING_LP];
						olen_next = blen_reg[RING_LP];
					end
					else if (pick == SRC_IRQ_BATCH && pend_reg[RING_IRQ])
					begin
						pend_next[RING_IRQ] = 1'b0;
						batch_go_next = 1'b1;
						oaddr_next = baddr_reg[RING_IRQ];
						olen_next = blen_reg[RING_IRQ];
					end
				end
			end
			ST_RUN:
			begin
				if (take)
				begin
					// by default ring instructions of the low stream rearbitrate
					if (src_reg == SRC_LP_RING)
						st_next = ST_ARB;
					if (instr_kind == KIND_ARB &&
						(src_reg == SRC_LP_RING || src_reg == SRC_LP_BATCH))
						arb_en_next = instr_arb_on;
					if (instr_kind == KIND_STORE_IMM && from_batch && prot_reg[ring])
					begin
						st_next = ST_HALT;
						err_hdr_next = instr_header;
						err_info_next = 32'h0000_0000;
						err_info_next[INFO_ORIGIN +: 3] = src_reg;
						err_info_next[INFO_CODE +: 8] = ERR_CODE_STORE_IMM;
						virq_next = ctrl_reg[CTRL_INT_EN] && !ctrl_reg[CTRL_INT_MASK];
						vhws_next = ctrl_reg[CTRL_HWS_EN] && !ctrl_reg[CTRL_HWS_MASK];
					end
					else if (instr_kind == KIND_BATCH && (!from_batch || instr_last))
					begin
						bact_next[ring] = 1'b1;
						pend_next[ring] = 1'b1;
						baddr_next[ring] = instr_batch_addr;
						blen_next[ring] = instr_batch_len;
						// a chained start inherits protection and cannot lift it
						if (!from_batch)
							prot_next[ring] = instr_untrusted;
						st_next = ST_ARB;
					end
					else if (from_batch && instr_last)
					begin
						// ring resumes at its head, already past the batch start
						bact_next[ring] = 1'b0;
						prot_next[ring] = 1'b0;
						st_next = ST_ARB;
					end
					else if (instr_kind == KIND_WAIT && !evt_hit)
					begin
						if (from_batch)
						begin
							stall_sel_next = instr_evt_sel;
							st_next = ST_STALL;
						end
						else
						begin
							wait_next[ring] = 1'b1;
							wsel_next[ring] = instr_evt_sel;
							st_next = ST_ARB;
						end
					end
				end
				else if (src_reg == SRC_IRQ_RING && !irq_rdy)
					st_next = ST_ARB;
			end
			ST_STALL:
			begin
				// the parser simply sits here; no other source is considered
				if (evt_in[stall_sel_reg])
					st_next = ST_RUN;
			end
			ST_HALT:
				st_next = ST_HALT;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= ST_ARB;
			src_reg <= SRC_NONE;
			bact_reg <= 2'h0;
			pend_reg <= 2'h0;
			prot_reg <= 2'h0;
			baddr_reg <= '{default: '0};
			blen_reg <= '{default: '0};
			wait_reg <= 2'h0;
			wsel_reg <= '{default: '0};
			stall_sel_reg <= '0;
			arb_en_reg <= 1'b1;
			err_hdr_reg <= 32'h0000_0000;
			err_info_reg <= 32'h0000_0000;
			oaddr_reg <= '0;
			olen_reg <= '0;
			src_go_reg <= 1'b0;
			batch_go_reg <= 1'b0;
			virq_reg <= 1'b0;
			vhws_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			src_reg <= src_next;
			bact_reg <= bact_next;
			pend_reg <= pend_next;
			prot_reg <= prot_next;
			baddr_reg <= baddr_next;
			blen_reg <= blen_next;
			wait_reg <= wait_next;
			wsel_reg <= wsel_next;
			stall_sel_reg <= stall_sel_next;
			arb_en_reg <= arb_en_next;
			err_hdr_reg <= err_hdr_next;
			err_info_reg <= err_info_next;
			oaddr_reg <= oaddr_next;
			olen_reg <= olen_next;
			src_go_reg <= src_go_next;
			batch_go_reg <= batch_go_next;
			virq_reg <= virq_next;
			vhws_reg <= vhws_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs and status

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[STAT_HALT] = (st_reg == ST_HALT);
		status_word[STAT_SRC +: 3] = src_reg;
		status_word[STAT_ARB_EN] = arb_en_reg;
		status_word[STAT_WAIT +: 2] = wait_reg;
		status_word[STAT_BACT +: 2] = bact_reg;
		status_word[STAT_PROT +: 2] = prot_reg;
	end

	assign src_sel = src_reg;
	assign src_go = src_go_reg;
	assign batch_go = batch_go_reg;
	assign batch_addr = oaddr_reg;
	assign batch_len = olen_reg;
	assign prot_mode = from_batch && prot_reg[ring];
	assign halted = (st_reg == ST_HALT);
	assign viol_irq = virq_reg;
	assign viol_hws_req = vhws_reg;

endmodule

`default_nettype wire

/* File: verification/bra_arbiter_props.sv */
// concurrent checks on the arbiter's instruction stream and violation outputs
// assumes the single clk domain and the async active-low reset of the arbiter
`default_nettype none

module bra_arbiter_props
	import bra_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire bra_pkg::bra_kind_e instr_kind,
	input wire logic instr_last,
	input wire bra_pkg::bra_src_e src_sel,
	input wire logic src_go,
	input wire logic batch_go,
	input wire logic prot_mode,
	input wire logic halted,
	input wire logic viol_irq,
	input wire logic viol_hws_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic take;
	logic bad_take;
	assign take = instr_valid && instr_ready;
	assign bad_take = take && instr_kind == KIND_STORE_IMM && prot_mode;

	////////////////////////////////////////////////////////////////////////
	a_halt_sticky: assert property (halted |=> halted)
		else $error("halt released without reset");
	a_halt_no_work: assert property (halted |-> !instr_ready && !src_go)
		else $error("work accepted while halted");
	a_viol_cause: assert property ($rose(halted) |-> $past(bad_take))
		else $error("halt without protected store");
	a_viol_halts: assert property (bad_take |=> halted)
		else $error("protected store not refused");
	a_unprot_store: assert property (take && instr_kind == KIND_STORE_IMM && !prot_mode
		|=> !halted) else $error("unprotected store refused");
	a_viol_pulse: assert property ((viol_irq || viol_hws_req) |-> $rose(halted))
		else $error("violation pulse without violation");
	a_batch_go_src: assert property (batch_go |-> src_go &&
		src_sel inside {SRC_LP_BATCH, SRC_IRQ_BATCH}) else $error("batch start off a batch");
	a_prot_batch: assert property (prot_mode |-> src_sel inside {SRC_LP_BATCH, SRC_IRQ_BATCH})
		else $error("protection outside a batch");
	a_lp_ring_arb: assert property (take && src_sel == SRC_LP_RING |=> !instr_ready)
		else $error("no arbitration after ring instruction");
	a_lp_batch_hold: assert property (take && src_sel == SRC_LP_BATCH && !instr_last &&
		!bad_take |=> src_sel == SRC_LP_BATCH [*2]) else $error("low batch preempted");
	a_irq_batch_hold: assert property (take && src_sel == SRC_IRQ_BATCH && !bad_take &&
		(!instr_last || instr_kind == KIND_BATCH) |=> src_sel == SRC_IRQ_BATCH [*2])
		else $error("interrupt batch preempted");
	a_go_ready: assert property (src_go |-> instr_ready)
		else $error("pick without run");
endmodule

bind bra_arbiter bra_arbiter_props u_props (.clk, .rst_n, .instr_valid, .instr_ready,
	.instr_kind, .instr_last, .src_sel, .src_go, .batch_go, .prot_mode, .halted, .viol_irq,
	.viol_hws_req);

`default_nettype wire

/* File: verification/bra_feed.sv */
// model of the instruction fetch side: hands one decoded instruction at a time
// assumes the arbiter's clk; a word is held until taken with instr_ready high
`default_nettype none

module bra_feed
	import bra_pkg::*;
(
	input wire logic clk,
	input wire logic instr_ready,
	output logic instr_valid,
	output logic [31:0] instr_header,
	output bra_pkg::bra_kind_e instr_kind,
	output logic instr_last,
	output logic [bra_pkg::ADDR_W-1:0] instr_batch_addr,
	output logic [bra_pkg::LEN_W-1:0] instr_batch_len,
	output logic instr_untrusted,
	output logic instr_arb_on,
	output logic [bra_pkg::EVT_SEL_W-1:0] instr_evt_sel
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		instr_valid = 1'b0;
		instr_header = 32'h0;
		instr_kind = KIND_OTHER;
		instr_last = 1'b0;
		instr_batch_addr = '0;
		instr_batch_len = '0;
		instr_untrusted = 1'b0;
		instr_arb_on = 1'b0;
		instr_evt_sel = '0;
	end

	task automatic put(input bra_kind_e k, input logic [31:0] h, input logic [ADDR_W-1:0] a,
		input logic [LEN_W-1:0] n, input logic u, input logic l, input logic [EVT_SEL_W-1:0] e,
		input logic o = 1'b0);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_kind <= k;
		instr_header <= h;
		instr_batch_addr <= a;
		instr_batch_len <= n;
		instr_untrusted <= u;
		instr_last <= l;
		instr_evt_sel <= e;
		instr_arb_on <= o;
		do @(posedge clk); while (!instr_ready);
		// released payload flips so stale data never passes for a fresh word
		instr_valid <= 1'b0;
		instr_header <= ~h;
		instr_batch_addr <= ~a;
		instr_batch_len <= ~n;
	endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the ring and batch stream arbiter
// assumes bra_feed as the fetch side; ring offsets and events are driven here
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bra_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, instr_header;
	logic [OFS_W-1:0] lp_head = '0, lp_tail = '0, irq_head = '0, irq_tail = '0;
	logic [EVT_W-1:0] evt_in = '0;
	logic instr_valid, instr_ready, instr_last, instr_untrusted, instr_arb_on;
	bra_kind_e instr_kind;
	logic [ADDR_W-1:0] instr_batch_addr, batch_addr;
	logic [LEN_W-1:0] instr_batch_len, batch_len;
	logic [EVT_SEL_W-1:0] instr_evt_sel;
	bra_src_e src_sel;
	logic src_go, batch_go, prot_mode, halted, viol_irq, viol_hws_req;
	int err_count = 0;
	int n_checks = 0;

	always #2 clk = ~clk;

	bra_arbiter u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lp_head, .lp_tail, .irq_head, .irq_tail,
		.evt_in, .instr_valid, .instr_ready, .instr_header, .instr_kind, .instr_last,
		.instr_batch_addr, .instr_batch_len, .instr_untrusted, .instr_arb_on, .instr_evt_sel,
		.src_sel, .src_go, .batch_go, .batch_addr, .batch_len, .prot_mode, .halted,
		.viol_irq, .viol_hws_req);

	bra_feed u_feed (.clk, .instr_ready, .instr_valid, .instr_header, .instr_kind,
		.instr_last, .instr_batch_addr, .instr_batch_len, .instr_untrusted, .instr_arb_on,
		.instr_evt_sel);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] v, input logic [1:0] re);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(re));
	endtask

	task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] v, input logic [1:0] re);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, v);
		chk(32'(s_axi_rresp), 32'(re));
	endtask

	// waits for the next pick; bounded so a missing pick shows as a mismatch
	task automatic go(input bra_src_e s, input logic b);
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			#1;
			i++;
		end
		while (src_go !== 1'b1 && i < 100);
		chk(32'(src_go), 32'h1);
		chk(32'(src_sel), 32'(s));
		chk(32'(batch_go), 32'(b));
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#40000;
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		results;
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(REG_CTRL, 32'h0, RESP_OKAY);
		rd(8'h10, 32'h0, RESP_SLVERR);
		wr(8'h10, 32'h1, RESP_SLVERR);
		wr(REG_CTRL, 32'h7, RESP_OKAY);
		rd(REG_CTRL, 32'h7, RESP_OKAY);
		$display("test registers done");
		lp_tail <= 19'h1;
		go(SRC_LP_RING, 1'b0);
		u_feed.put(KIND_BATCH, 32'h1, 32'h1000, 32'h40, 1'b0, 1'b0, 2'h0);
		go(SRC_LP_BATCH, 1'b1);
		chk(batch_addr, 32'h1000);
		chk(batch_len, 32'h40);
		u_feed.put(KIND_BATCH, 32'h2, 32'h2000, 32'h20, 1'b0, 1'b1, 2'h0);
		go(SRC_LP_BATCH, 1'b1);
		chk(batch_addr, 32'h2000);
		$display("test batch chain done");
		irq_tail <= 19'h1;
		u_feed.put(KIND_OTHER, 32'h3, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0);
		repeat (4) @(posedge clk);
		#1;
		chk(32'(src_sel), 32'(SRC_LP_BATCH));
		u_feed.put(KIND_BATCH, 32'h4, 32'h3000, 32'h10, 1'b0, 1'b1, 2'h0);
		go(SRC_IRQ_RING, 1'b0);
		u_feed.put(KIND_WAIT, 32'h5, 32'h0, 32'h0, 1'b0, 1'b0, 2'h2);
		go(SRC_LP_BATCH, 1'b1);
		chk(batch_addr, 32'h3000);
		u_feed.put(KIND_OTHER, 32'h6, 32'h0, 32'h0, 1'b0, 1'b1, 2'h0);
		go(SRC_LP_RING, 1'b0);
		evt_in <= 4'h4;
		u_feed.put(KIND_OTHER, 32'h7, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0);
		go(SRC_IRQ_RING, 1'b0);
		irq_head <= 19'h1;
		u_feed.put(KIND_OTHER, 32'h8, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0);
		go(SRC_LP_RING, 1'b0);
		irq_tail <= 19'h2;
		u_feed.put(KIND_ARB, 32'hb, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0, 1'b0);
		go(SRC_LP_RING, 1'b0);
		u_feed.put(KIND_ARB, 32'hc, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0, 1'b1);
		go(SRC_IRQ_RING, 1'b0);
		u_feed.put(KIND_BATCH, 32'hd, 32'h6000, 32'h8, 1'b0, 1'b0, 2'h0);
		go(SRC_IRQ_BATCH, 1'b1);
		u_feed.put(KIND_WAIT, 32'he, 32'h0, 32'h0, 1'b0, 1'b0, 2'h1);
		repeat (3) @(posedge clk);
		#1;
		chk(32'(instr_ready), 32'h0);
		chk(32'(src_sel), 32'(SRC_IRQ_BATCH));
		evt_in <= 4'h6;
		u_feed.put(KIND_BATCH, 32'hf, 32'h7000, 32'h8, 1'b0, 1'b1, 2'h0);
		go(SRC_IRQ_BATCH, 1'b1);
		chk(batch_addr, 32'h7000);
		u_feed.put(KIND_OTHER, 32'h10, 32'h0, 32'h0, 1'b0, 1'b1, 2'h0);
		go(SRC_IRQ_RING, 1'b0);
		u_feed.put(KIND_WAIT, 32'h11, 32'h0, 32'h0, 1'b0, 1'b0, 2'h2);
		#1;
		chk(32'(instr_ready), 32'h1);
		irq_head <= 19'h2;
		go(SRC_LP_RING, 1'b0);
		$display("test arbitration done");
		u_feed.put(KIND_BATCH, 32'h9, 32'h4000, 32'h8, 1'b1, 1'b0, 2'h0);
		go(SRC_LP_BATCH, 1'b1);
		chk(32'(prot_mode), 32'h1);
		u_feed.put(KIND_BATCH, 32'ha, 32'h5000, 32'h8, 1'b0, 1'b1, 2'h0);
		go(SRC_LP_BATCH, 1'b1);
		chk(32'(prot_mode), 32'h1);
		u_feed.put(KIND_STORE_IMM, 32'h1234_5678, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0);
		// violation pulses stand for one cycle only, right after the refused word
		#1;
		chk(32'(halted), 32'h1);
		chk(32'(viol_irq), 32'h1);
		chk(32'(viol_hws_req), 32'h0);
		rd(REG_ERR_HDR, 32'h1234_5678, RESP_OKAY);
		rd(REG_ERR_INFO, 32'h0000_0103, RESP_OKAY);
		lp_tail <= 19'h2;
		repeat (20) @(posedge clk);
		#1;
		chk(32'(halted), 32'h1);
		chk(32'(instr_ready), 32'h0);
		$display("test protected mode done");
		results;
	end
endmodule

`default_nettype wire
